// [common/cic_params.svh]
`ifndef CIC_PARAMS_SVH
`define CIC_PARAMS_SVH
// Operation
// - Each flag is kept, cleared, set, taken from result, undefined, or restored.
// - Branch cost includes queue reload and target fetch clocks.
// - Wide bus: odd-address word reference adds four clocks.
// - Narrow bus: every 16-bit memory reference, stack included, adds four clocks.
// - Each instruction has a base-core count and an enhanced-core count.
// - Narrow bus: byte ops use listed count, word ops add 4 per transfer.
// - Repeat cost is start count plus per-iteration count times repeat number.
// - Fast instructions below two clocks per byte drain the queue and stall.
// - Address cost: 6, 5, 9, 7 or 8, 11 or 12 clocks by components.
// - Segment override adds 2 clocks to address cost.
// - Operand waits at most one clock behind a started fetch cycle.
// - With a full queue the operand request waits no clocks.
// - Word constants span 0-FFFFH, byte constants span 0-FFH.
// - Short branch reaches -128 to +127 bytes from instruction end.
// - Translate indexes a 256-byte table in memory.
// - Far indirect pointer doubleword loads both offset and segment.
// - Timing for a sequence is exactly repeatable under equal conditions.
`define CIC_EA_ADDR_OFFSET_FIELD     24'h000006
`define CIC_EA_BI       24'h000005
`define CIC_EA_DBI      24'h000009
`define CIC_EA_PAIR7    24'h000007
`define CIC_EA_PAIR8    24'h000008
`define CIC_EA_DPAIR11  24'h00000B
`define CIC_EA_DPAIR12  24'h00000C
`define CIC_SEG_OVR     24'h000002
`define CIC_FETCH_WAIT  24'h000001
`define CIC_QDEPTH      3'h6
`define CIC_TBL_DEPTH   256
`endif

// [common/cic_pkg.sv]
package cic_pkg;
    typedef logic [23:0] cic_clk_t;
    typedef enum logic [2:0] {
        EA_NONE, EA_ADDR_OFFSET_FIELD, EA_BI, EA_DBI, EA_PAIR7, EA_PAIR8, EA_DPAIR11, EA_DPAIR12
    } cic_ea_e;
    typedef enum logic [2:0] {
        FL_KEEP, FL_CLR, FL_SET, FL_RES, FL_UNDEF, FL_REST
    } cic_flag_e;
    typedef enum logic [2:0] {
        ST_IDLE, ST_REP, ST_QUEUE, ST_BUS, ST_DONE
    } cic_state_e;
endpackage

// [hdl/cic_xlat_mem.sv]
`timescale 1ns/10ps
`default_nettype none
`include "cic_params.svh"
module cic_xlat_mem
    import cic_pkg::*;
(
    input  wire logic       clk,     // Core clock
    input  wire logic       srst,    // Sync reset
    input  wire logic       ce,      // Clock enable
    input  wire logic       wr_en,   // Table write strobe
    input  wire logic [7:0] wr_addr, // Table write index
    input  wire logic [7:0] wr_data, // Table write byte
    input  wire logic       rd_en,   // Lookup strobe
    input  wire logic [7:0] rd_addr, // Lookup index
    output logic      [7:0] rd_data  // Registered lookup byte
);
    logic [7:0] mem [0:`CIC_TBL_DEPTH-1];

    // Storage carries no reset; contents are software's job
    always_ff @(posedge clk) begin
        if (ce && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read so the top's output comes from a flop
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_data <= 8'h00;
        end else if (ce && rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule
`default_nettype wire

// [hdl/cic_cost.sv]
`timescale 1ns/10ps
`default_nettype none
`include "cic_params.svh"
module cic_cost
    import cic_pkg::*;
(
    input  wire logic        clk,         // 25 MHz core clock
    input  wire logic        srst,        // Sync reset, high
    input  wire logic        ce,          // Clock enable, freezes all
    input  wire logic        req_valid,   // Costing request
    input  wire logic        req_core,    // 0 base core, 1 enhanced core
    input  wire logic        req_narrow,  // 8-bit external bus variant
    input  wire logic        req_word,    // Word operation
    input  wire logic [15:0] clk_n,       // Base-core start count
    input  wire logic [15:0] clk_m,       // Enhanced-core start count
    input  wire logic [15:0] iter_n,      // Base-core per-iteration count
    input  wire logic [15:0] iter_m,      // Enhanced-core per-iteration count
    input  wire logic        rep_en,      // Repeated instruction
    input  wire logic [15:0] rep_count,   // Repeat number
    input  wire logic        mem_op,      // Memory operand present
    input  wire cic_ea_e     ea_mode,     // Address components
    input  wire logic        seg_ovr,     // Segment override applies
    input  wire logic        odd_addr,    // Word operand at odd address
    input  wire logic [2:0]  xfers,       // Memory data transfers
    input  wire logic        branch,      // Control transfer
    input  wire logic [2:0]  instr_bytes, // Opcode bytes consumed
    input  wire logic        bus_avail,   // Bus free, asynchronous pin
    input  wire logic [26:0] flag_act,    // Three bits per flag
    input  wire logic [8:0]  flag_old,    // Flags before
    input  wire logic [8:0]  flag_res,    // Flags from result
    input  wire logic [8:0]  flag_saved,  // Earlier saved flags
    input  wire logic        imm_byte,    // Immediate is byte_constant
    input  wire logic [15:0] imm_val,     // Immediate value
    input  wire logic [15:0] br_end,      // Address after the branch
    input  wire logic [7:0]  br_addr_offset_field,     // Short branch displacement
    input  wire logic        far_load,    // Load far_indirect_pointer
    input  wire logic [31:0] far_ptr,     // Offset low, segment high
    input  wire logic        tbl_wr,      // Translate table write
    input  wire logic [7:0]  tbl_waddr,   // Table write index
    input  wire logic [7:0]  tbl_wdata,   // Table write byte
    input  wire logic        tbl_rd,      // Translate lookup
    input  wire logic [7:0]  tbl_index,   // Lookup index
    output logic             busy,        // Costing in progress
    output logic             cost_valid,  // One-cycle result strobe
    output cic_clk_t         cost_total,  // Total clocks
    output logic      [2:0]  queue_level, // Prefetch queue bytes
    output logic      [8:0]  flag_new,    // Resulting flags
    output logic      [8:0]  flag_undef,  // Flags holding no reliable value
    output logic             imm_ok,      // Immediate in range
    output logic      [15:0] br_target,   // Short branch target
    output logic      [15:0] far_offset,  // Far target offset
    output logic      [15:0] far_segment, // Far target segment
    output logic      [7:0]  tbl_data,    // Translated byte
    output logic             tbl_valid    // Translated byte strobe
);
    cic_state_e state;
    cic_state_e next_state;
    cic_clk_t   acc;
    cic_clk_t   iter_q;
    logic [15:0] rep_left;
    logic        mem_q;
    logic        branch_q;
    logic [2:0]  bytes_q;
    logic        bus_s1;
    logic        bus_s2;
    logic        bus_s3;
    logic        bus_ok;
    logic        accept;
    logic [15:0] base_sel;
    logic [15:0] iter_sel;
    cic_clk_t    ea_c;
    cic_clk_t    pen_c;
    cic_clk_t    static_c;
    cic_clk_t    iter_c;
    cic_clk_t    stall_c;
    cic_clk_t    wait_c;
    cic_clk_t    fill_sum;
    logic [2:0]  kept;

    assign accept = ce && req_valid && (state == ST_IDLE);

    // Core pick and address cost
    always_comb begin
        base_sel = req_core ? clk_m : clk_n;
        iter_sel = req_core ? iter_m : iter_n;
        case (ea_mode)
            EA_ADDR_OFFSET_FIELD:    ea_c = `CIC_EA_ADDR_OFFSET_FIELD;
            EA_BI:      ea_c = `CIC_EA_BI;
            EA_DBI:     ea_c = `CIC_EA_DBI;
            EA_PAIR7:   ea_c = `CIC_EA_PAIR7;
            EA_PAIR8:   ea_c = `CIC_EA_PAIR8;
            EA_DPAIR11: ea_c = `CIC_EA_DPAIR11;
            EA_DPAIR12: ea_c = `CIC_EA_DPAIR12;
            default:    ea_c = 24'h000000;
        endcase
        if (mem_op && seg_ovr) begin
            ea_c = ea_c + `CIC_SEG_OVR;
        end
    end

    // Four clocks per transfer, shared by odd and narrow penalties
    assign pen_c = 24'({xfers, 2'h0});

    // Start part; narrow word penalty moves into the loop when repeating
    always_comb begin
        static_c = 24'(base_sel) + ea_c;
        if (!req_narrow && req_word && odd_addr) begin
            static_c = static_c + pen_c;
        end
        if (req_narrow && req_word && !rep_en) begin
            static_c = static_c + pen_c;
        end
        iter_c = 24'(iter_sel);
        if (req_narrow && req_word) begin
            iter_c = iter_c + pen_c;
        end
    end

    // Queue stall and fetch wait, from the level before consumption
    always_comb begin
        stall_c = 24'h000000;
        kept    = 3'h0;
        if (bytes_q > queue_level) begin
            stall_c = 24'({3'(bytes_q - queue_level), 1'h0});
        end else begin
            kept = 3'(queue_level - bytes_q);
        end
        wait_c = 24'h000000;
        if (mem_q && (queue_level != `CIC_QDEPTH)) begin
            wait_c = `CIC_FETCH_WAIT;
        end
        fill_sum = 24'(kept) + (acc >> 1);
    end

    // Sequencer; latency set by repeat count and, for memory operands, by the synchronised bus_ok
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (accept) begin
                    next_state = (rep_en && rep_count != 16'h0000) ? ST_REP : ST_QUEUE;
                end
            end
            ST_REP: begin
                if (rep_left == 16'h0001) begin
                    next_state = ST_QUEUE;
                end
            end
            ST_QUEUE: begin
                next_state = (mem_q && !bus_ok) ? ST_BUS : ST_DONE;
            end
            ST_BUS: begin
                if (bus_ok) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= ST_IDLE;
            busy  <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            busy  <= (next_state != ST_IDLE);
        end
    end

    // Three-stage pin sync; only agreeing later stages move bus_ok
    always_ff @(posedge clk) begin
        if (srst) begin
            bus_s1 <= 1'b0;
            bus_s2 <= 1'b0;
            bus_s3 <= 1'b0;
            bus_ok <= 1'b0;
        end else if (ce) begin
            bus_s1 <= bus_avail;
            bus_s2 <= bus_s1;
            bus_s3 <= bus_s2;
            if (bus_s2 == bus_s3) begin
                bus_ok <= bus_s3;
            end
        end
    end

    // Clock accumulator
    always_ff @(posedge clk) begin
        if (srst) begin
            acc    <= 24'h000000;
            iter_q <= 24'h000000;
        end else if (ce) begin
            case (state)
                ST_IDLE: begin
                    if (accept) begin
                        acc    <= static_c;
                        iter_q <= iter_c;
                    end
                end
                ST_REP:   acc <= acc + iter_q;
                ST_QUEUE: acc <= acc + stall_c + wait_c;
                ST_BUS: begin
                    if (!bus_ok) begin
                        acc <= acc + 24'h000001;
                    end
                end
                default: acc <= acc;
            endcase
        end
    end

    // Repeat counter and per-request context
    always_ff @(posedge clk) begin
        if (srst) begin
            rep_left <= 16'h0000;
            mem_q    <= 1'b0;
            branch_q <= 1'b0;
            bytes_q  <= 3'h0;
        end else if (ce) begin
            if (accept) begin
                rep_left <= rep_count;
                mem_q    <= mem_op;
                branch_q <= branch;
                bytes_q  <= instr_bytes;
            end else if (state == ST_REP) begin
                rep_left <= rep_left - 16'h0001;
            end
        end
    end

    // Queue refills one byte per two clocks; a branch empties it
    always_ff @(posedge clk) begin
        if (srst) begin
            queue_level <= 3'h0;
        end else if (ce && state == ST_QUEUE) begin
            if (branch_q) begin
                queue_level <= 3'h0;
            end else if (fill_sum >= 24'(`CIC_QDEPTH)) begin
                queue_level <= `CIC_QDEPTH;
            end else begin
                queue_level <= fill_sum[2:0];
            end
        end
    end

    // Result strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            cost_valid <= 1'b0;
            cost_total <= 24'h000000;
        end else if (ce) begin
            cost_valid <= (state == ST_DONE);
            if (state == ST_DONE) begin
                cost_total <= acc;
            end
        end
    end

    // Per-flag effect decode
    genvar gi;
    generate
        for (gi = 0; gi < 9; gi++) begin : g_flag
            always_ff @(posedge clk) begin
                if (srst) begin
                    flag_new[gi]   <= 1'b0;
                    flag_undef[gi] <= 1'b0;
                end else if (accept) begin
                    flag_undef[gi] <= (cic_flag_e'(flag_act[3*gi +: 3]) == FL_UNDEF);
                    case (cic_flag_e'(flag_act[3*gi +: 3]))
                        FL_CLR:  flag_new[gi] <= 1'b0;
                        FL_SET:  flag_new[gi] <= 1'b1;
                        FL_RES:  flag_new[gi] <= flag_res[gi];
                        FL_REST: flag_new[gi] <= flag_saved[gi];
                        default: flag_new[gi] <= flag_old[gi];
                    endcase
                end
            end
        end
    endgenerate

    // Operand range checks and transfer targets
    always_ff @(posedge clk) begin
        if (srst) begin
            imm_ok      <= 1'b0;
            br_target   <= 16'h0000;
            far_offset  <= 16'h0000;
            far_segment <= 16'h0000;
        end else if (accept) begin
            imm_ok    <= !imm_byte || (imm_val[15:8] == 8'h00);
            br_target <= br_end + {{8{br_addr_offset_field[7]}}, br_addr_offset_field};
            if (far_load) begin
                far_offset  <= far_ptr[15:0];
                far_segment <= far_ptr[31:16];
            end
        end
    end

    // Translate table
    cic_xlat_mem u_tbl (
        .clk     (clk),
        .srst    (srst),
        .ce      (ce),
        .wr_en   (tbl_wr),
        .wr_addr (tbl_waddr),
        .wr_data (tbl_wdata),
        .rd_en   (tbl_rd),
        .rd_addr (tbl_index),
        .rd_data (tbl_data)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            tbl_valid <= 1'b0;
        end else if (ce) begin
            tbl_valid <= tbl_rd;
        end
    end

    // Checks; a frozen cycle disables them
    sequence s_accept;
        ce && req_valid && (state == ST_IDLE);
    endsequence
    sequence s_done3;
        ##3 cost_valid;
    endsequence

    property p_ea_seg;
        @(posedge clk) disable iff (srst || !ce)
        s_accept ##0 (mem_op && ea_mode == EA_DBI && seg_ovr && !req_word && !rep_en)
        |=> acc == 24'($past(base_sel)) + 24'h00000B;
    endproperty
    a_ea_seg: assert property (p_ea_seg) else $error("address plus override cost wrong");

    property p_ea_pair;
        @(posedge clk) disable iff (srst || !ce)
        s_accept ##0 (mem_op && ea_mode == EA_PAIR8 && !seg_ovr && !req_word && !rep_en)
        |=> acc == 24'($past(base_sel)) + 24'h000008;
    endproperty
    a_ea_pair: assert property (p_ea_pair) else $error("base plus index cost wrong");

    property p_odd;
        @(posedge clk) disable iff (srst || !ce)
        s_accept ##0 (ea_mode == EA_NONE && !seg_ovr && !req_narrow && req_word && odd_addr && !rep_en)
        |=> acc == 24'($past(base_sel)) + 24'({$past(xfers), 2'h0});
    endproperty
    a_odd: assert property (p_odd) else $error("odd word penalty wrong");

    property p_narrow;
        @(posedge clk) disable iff (srst || !ce)
        s_accept ##0 (ea_mode == EA_NONE && !seg_ovr && req_narrow && req_word && !rep_en)
        |=> acc == 24'($past(base_sel)) + 24'({$past(xfers), 2'h0});
    endproperty
    a_narrow: assert property (p_narrow) else $error("narrow bus penalty wrong");

    property p_rep;
        @(posedge clk) disable iff (srst || !ce)
        (state == ST_REP && rep_left > 16'h0001)
        |=> state == ST_REP && acc == $past(acc) + iter_q;
    endproperty
    a_rep: assert property (p_rep) else $error("repeat step wrong");

    property p_wait1;
        @(posedge clk) disable iff (srst || !ce)
        (state == ST_QUEUE && mem_q && queue_level != `CIC_QDEPTH && bytes_q <= queue_level)
        |=> acc == $past(acc) + 24'h000001;
    endproperty
    a_wait1: assert property (p_wait1) else $error("fetch wait not one clock");

    property p_nowait;
        @(posedge clk) disable iff (srst || !ce)
        (state == ST_QUEUE && queue_level == `CIC_QDEPTH && bytes_q <= queue_level)
        |=> acc == $past(acc);
    endproperty
    a_nowait: assert property (p_nowait) else $error("full queue still waited");

    property p_flush;
        @(posedge clk) disable iff (srst || !ce)
        (state == ST_QUEUE && branch_q) |=> queue_level == 3'h0;
    endproperty
    a_flush: assert property (p_flush) else $error("queue not emptied on branch");

    property p_restore;
        @(posedge clk) disable iff (srst || !ce)
        s_accept ##0 (flag_act[2:0] == FL_REST) |=> flag_new[0] == $past(flag_saved[0]);
    endproperty
    a_restore: assert property (p_restore) else $error("flag not restored");

    property p_short;
        @(posedge clk) disable iff (srst || !ce)
        s_accept |=> br_target == $past(br_end) + {{8{$past(br_addr_offset_field[7])}}, $past(br_addr_offset_field)};
    endproperty
    a_short: assert property (p_short) else $error("short target wrong");

    property p_imm;
        @(posedge clk) disable iff (srst || !ce)
        s_accept ##0 (imm_byte && imm_val[15:8] != 8'h00) |=> !imm_ok;
    endproperty
    a_imm: assert property (p_imm) else $error("byte constant range not flagged");

    property p_fixed;
        @(posedge clk) disable iff (srst || !ce)
        s_accept ##0 (!rep_en && !mem_op) |-> s_done3;
    endproperty
    a_fixed: assert property (p_fixed) else $error("latency not fixed");
endmodule
`default_nettype wire

// [sim/cic_bus_model.sv]
`timescale 1ns/10ps
`default_nettype none
module cic_bus_model (
    input  wire logic clk,      // Core clock
    input  wire logic hold,     // Competing master owns the bus
    output logic      bus_avail // Bus free pin
);
    // Bus is granted on demand unless another master holds it; the pin follows hold, inverted, one clock later
    always_ff @(posedge clk) begin
        bus_avail <= ~hold;
    end
endmodule
`default_nettype wire

// [sim/tb_cpu_instruction_cycle_costing.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_cpu_instruction_cycle_costing import cic_pkg::*;;
    logic        clk = 1'b0, srst = 1'b1, ce = 1'b1, hold = 1'b0;
    logic        req_valid, req_core, req_narrow, req_word, rep_en, mem_op, seg_ovr, odd_addr, branch;
    logic        imm_byte, far_load, tbl_wr, tbl_rd, busy, cost_valid, imm_ok, tbl_valid;
    logic [15:0] clk_n, clk_m, iter_n, iter_m, rep_count, imm_val, br_end, br_target, far_offset, far_segment;
    logic [2:0]  xfers, instr_bytes, queue_level;
    logic [7:0]  br_addr_offset_field, tbl_waddr, tbl_wdata, tbl_index, tbl_data;
    logic [26:0] flag_act;
    logic [8:0]  flag_old, flag_res, flag_saved, flag_new, flag_undef;
    logic [31:0] far_ptr;
    cic_ea_e     ea_mode;
    cic_clk_t    cost_total;
    wire logic   bus_avail;
    int          miscompares = 0, check_count = 0;
    cic_clk_t    ea_tab [8] = '{24'h0, 24'h6, 24'h5, 24'h9, 24'h7, 24'h8, 24'hB, 24'hC};

    cic_cost dut_u (.clk, .srst, .ce, .req_valid, .req_core, .req_narrow, .req_word, .clk_n, .clk_m,
        .iter_n, .iter_m, .rep_en, .rep_count, .mem_op, .ea_mode, .seg_ovr, .odd_addr, .xfers, .branch,
        .instr_bytes, .bus_avail, .flag_act, .flag_old, .flag_res, .flag_saved, .imm_byte, .imm_val,
        .br_end, .br_addr_offset_field, .far_load, .far_ptr, .tbl_wr, .tbl_waddr, .tbl_wdata, .tbl_rd, .tbl_index,
        .busy, .cost_valid, .cost_total, .queue_level, .flag_new, .flag_undef, .imm_ok, .br_target,
        .far_offset, .far_segment, .tbl_data, .tbl_valid);
    cic_bus_model bus_u (.clk(clk), .hold(hold), .bus_avail(bus_avail));

    // Free-running core clock
    always #20 clk = ~clk;

    task automatic chk(input cic_clk_t got, input cic_clk_t exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // Quiet defaults; a branch empties the queue so every cost starts from a known level
    task automatic clr();
        {req_valid, req_core, req_narrow, req_word, rep_en, mem_op, seg_ovr, odd_addr} = 8'h00;
        {imm_byte, far_load, tbl_wr, tbl_rd} = 4'h0;
        branch = 1'b1;
        {clk_n, clk_m, iter_n, iter_m, rep_count} = {16'h000A, 16'h0014, 16'h0005, 16'h0003, 16'h0000};
        {xfers, instr_bytes, ea_mode} = {3'h0, 3'h0, EA_NONE};
        {flag_act, flag_old, flag_res, flag_saved} = {27'h0, 9'h155, 9'h0AA, 9'h1C3};
        {imm_val, br_end, br_addr_offset_field, far_ptr} = {16'h0000, 16'h1000, 8'h00, 32'h0};
        {tbl_waddr, tbl_wdata, tbl_index} = 24'h0;
    endtask

    // One request, held for exactly one taking edge, then a bounded wait for the result strobe
    task automatic req(output cic_clk_t t);
        int n;
        n = 0;
        @(posedge clk);
        #1 req_valid = 1'b1;
        @(posedge clk);
        #1 req_valid = 1'b0;
        while (cost_valid !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= 200) miscompares++;
        t = cost_total;
    endtask

    task automatic t_ea();
        cic_clk_t t;
        for (int m = 0; m < 8; m++) begin
            clr();
            mem_op = 1'b1;
            ea_mode = cic_ea_e'(m);
            seg_ovr = m[0];
            req(t);
            chk(t, 24'hA + ea_tab[m] + (m[0] ? 24'h2 : 24'h0) + 24'h1);
        end
        $display("test ea done");
    endtask

    // Rows: narrow, word, odd, core, expected total with base 10, enhanced base 20, two transfers
    task automatic t_bus();
        cic_clk_t t, t2;
        logic [27:0] row [5] = '{{4'h1, 24'h14}, {4'hC, 24'h12}, {4'h8, 24'h0A}, {4'h5, 24'h14},
                                  {4'h7, 24'h1C}};
        for (int r = 0; r < 5; r++) begin
            clr();
            {req_narrow, req_word, odd_addr, req_core} = row[r][27:24];
            xfers = 3'h2;
            req(t);
            chk(t, row[r][23:0]);
        end
        req(t2);
        chk(t2, t);
        $display("test bus done");
    endtask

    task automatic t_rep();
        cic_clk_t t;
        clr();
        {rep_en, rep_count, clk_n, req_narrow, req_word, xfers} = {1'b1, 16'h0003, 16'h0009, 2'b11, 3'h1};
        req(t);
        chk(t, 24'h9 + 24'h3 * (24'h5 + 24'h4));
        $display("test rep done");
    endtask

    task automatic t_queue();
        cic_clk_t t;
        clr();
        branch = 1'b0;
        clk_n = 16'h000C;
        req(t);
        chk(t, 24'hC);
        chk(queue_level, 24'h6);
        clr();
        {mem_op, ea_mode} = {1'b1, EA_ADDR_OFFSET_FIELD};
        req(t);
        chk(t, 24'hA + 24'h6);
        clr();
        instr_bytes = 3'h2;
        req(t);
        chk(t, 24'hA + 24'h4);
        chk(queue_level, 24'h0);
        $display("test queue done");
    endtask

    task automatic t_misc();
        cic_clk_t t;
        logic [8:0] fn, fu;
        clr();
        for (int i = 0; i < 6; i++) flag_act[3*i +: 3] = 3'(i);
        {imm_byte, imm_val, br_addr_offset_field, far_load, far_ptr} = {1'b1, 16'h00FF, 8'h80, 1'b1, 32'h1234_5678};
        req(t);
        fn = flag_old;
        fu = 9'h000;
        for (int i = 0; i < 6; i++) begin
            case (i)
                1: fn[i] = 1'b0;
                2: fn[i] = 1'b1;
                3: fn[i] = flag_res[i];
                4: fu[i] = 1'b1;
                5: fn[i] = flag_saved[i];
                default: ;
            endcase
        end
        chk(flag_new, fn);
        chk(flag_undef, fu);
        chk(imm_ok, 24'h1);
        chk(br_target, br_end - 16'h0080);
        chk(far_offset, 24'h5678);
        chk(far_segment, 24'h1234);
        clr();
        {imm_byte, imm_val, br_addr_offset_field} = {1'b1, 16'h0100, 8'h7F};
        req(t);
        chk(imm_ok, 24'h0);
        chk(br_target, br_end + 16'h007F);
        clr();
        imm_val = 16'hFFFF;
        req(t);
        chk(imm_ok, 24'h1);
        $display("test misc done");
    endtask

    task automatic t_tbl();
        @(posedge clk);
        #1 {tbl_wr, tbl_waddr, tbl_wdata} = {1'b1, 8'h00, 8'h5A};
        @(posedge clk);
        #1 {tbl_waddr, tbl_wdata} = {8'hFF, 8'hA5};
        @(posedge clk);
        #1 {tbl_wr, tbl_rd, tbl_index} = {2'b01, 8'h00};
        @(posedge clk);
        #1 chk(tbl_valid, 24'h1);
        chk(tbl_data, 24'h5A);
        tbl_index = 8'hFF;
        @(posedge clk);
        #1 chk(tbl_data, 24'hA5);
        tbl_rd = 1'b0;
        @(posedge clk);
        #1 chk(tbl_valid, 24'h0);
        $display("test tbl done");
    endtask

    // Freeze mid-request, then a mid-run reset; a frozen cycle must not advance the count
    task automatic t_ce();
        cic_clk_t t;
        clr();
        fork
            req(t);
            begin
                repeat (2) @(posedge clk);
                #1 ce = 1'b0;
                repeat (5) @(posedge clk);
                #1 chk({busy, cost_valid}, 24'h2);
                ce = 1'b1;
            end
        join
        chk(t, 24'hA);
        @(posedge clk);
        #1 srst = 1'b1;
        @(posedge clk);
        #1 srst = 1'b0;
        chk(cost_total, 24'h0);
        $display("test ce done");
    endtask

    // Bus held by another master: the operand waits, so the count grows beyond the idle figure
    task automatic t_wait();
        cic_clk_t t;
        clr();
        {mem_op, ea_mode, hold} = {1'b1, EA_ADDR_OFFSET_FIELD, 1'b1};
        repeat (6) @(posedge clk);
        fork
            req(t);
            begin
                repeat (12) @(posedge clk);
                #1 chk(busy, 24'h1);
                hold = 1'b0;
            end
        join
        chk(24'(t > 24'h11), 24'h1);
        $display("test wait done");
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #200000;
        miscompares++;
        print_verdict();
    end

    initial begin
        clr();
        repeat (8) @(posedge clk);
        #1 srst = 1'b0;
        chk({busy, cost_valid, queue_level}, 24'h0);
        chk(cost_total, 24'h0);
        $display("test reset done");
        // The bus-free pin needs four edges through its synchroniser before operands run unstalled
        repeat (4) @(posedge clk);
        t_ea();
        t_bus();
        t_rep();
        t_queue();
        t_misc();
        t_tbl();
        t_ce();
        t_wait();
        print_verdict();
    end
endmodule
`default_nettype wire
